// file: level_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module level_debounce
  import rail_monitor_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_level,
  input wire logic [FILTER_COUNT_W-1:0] i_rise_cycles,
  input wire logic [FILTER_COUNT_W-1:0] i_fall_cycles,
  output logic o_level
);

  logic level_reg;
  logic level_next;
  logic [FILTER_COUNT_W-1:0] cnt_reg;
  logic [FILTER_COUNT_W-1:0] cnt_next;
  logic [FILTER_COUNT_W-1:0] target;

  // A zero target means no filtering; otherwise the new level must hold for
  // the whole target time, and any return to the old level restarts the count.
  always_comb begin
    level_next = level_reg;
    cnt_next = '0;
    target = level_reg ? i_fall_cycles : i_rise_cycles;
    if (i_level != level_reg) begin
      if (target == '0) begin
        level_next = i_level;
      end else if (cnt_reg >= target - 1'b1) begin
        level_next = i_level;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // State registers, frozen while the clock enable is low.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      level_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (i_clk_en) begin
      level_reg <= level_next;
      cnt_reg <= cnt_next;
    end
  end

  assign o_level = level_reg;

endmodule : level_debounce
`default_nettype wire

// file: rail_monitor_config.sv
`timescale 1ns/1ps
`default_nettype none
module rail_monitor_config
  import rail_monitor_pkg::*;
#(
  parameter int US_CYCLES = CYCLES_PER_US
)
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire reg_req_t i_reg_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_sequencer_enable,
  input wire logic i_seq_linear_rail_on,
  input wire logic i_seq_linear_rail_discharge,
  input wire logic i_buck_a_under_raw,
  input wire logic i_buck_a_over_raw,
  input wire logic i_buck_b_under_raw,
  input wire logic i_buck_b_over_raw,
  output logic o_linear_rail_on,
  output logic o_linear_rail_discharge,
  output logic [10:0] o_linear_rail_ramp_slope,
  output rail_limits_t o_buck_a_limits,
  output rail_limits_t o_buck_b_limits,
  output rail_fault_t o_buck_a_fault,
  output rail_fault_t o_buck_b_fault
);

  // Short filter codes: 000 is a bypass, others are 2 us doubling per step.
  function automatic logic [8:0] short_filter_us(input logic [2:0] code);
    logic [8:0] us;
    us = '0;
    if (code != 3'h0) begin
      us = SHORT_FILTER_UNIT_US << code;
    end
    return us;
  endfunction : short_filter_us

  // Long filter codes: 32 us doubling per step, never a bypass.
  function automatic logic [8:0] long_filter_us(input logic [1:0] code);
    return LONG_FILTER_BASE_US << code;
  endfunction : long_filter_us

  // Microseconds to clock cycles of the system clock.
  function automatic logic [FILTER_COUNT_W-1:0] us_to_cycles(input logic [8:0] us);
    return FILTER_COUNT_W'(int'(us) * US_CYCLES);
  endfunction : us_to_cycles

  // Trip-point table shared by both windows; the sign is given by the side.
  function automatic logic [6:0] threshold_permille(input logic [2:0] code);
    logic [6:0] pm;
    case (code)
      3'h0: pm = 7'h1e;
      3'h1: pm = 7'h23;
      3'h2: pm = 7'h28;
      3'h3: pm = 7'h2d;
      3'h4: pm = 7'h32;
      3'h5: pm = 7'h3c;
      3'h6: pm = 7'h50;
      default: pm = 7'h64;
    endcase
    return pm;
  endfunction : threshold_permille

  // Configuration registers.
  logic [LINEAR_USED_BITS-1:0] linear_cfg_reg;
  logic [LINEAR_USED_BITS-1:0] linear_cfg_next;
  under_cfg_t a_under_reg;
  under_cfg_t a_under_next;
  over_cfg_t a_over_reg;
  over_cfg_t a_over_next;
  under_cfg_t b_under_reg;
  under_cfg_t b_under_next;
  over_cfg_t b_over_reg;
  over_cfg_t b_over_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // Register writes; only the addressed register changes, so each monitor
  // register instance steers its own rail and nothing else.
  always_comb begin
    linear_cfg_next = linear_cfg_reg;
    a_under_next = a_under_reg;
    a_over_next = a_over_reg;
    b_under_next = b_under_reg;
    b_over_next = b_over_reg;
    if (i_reg_req.wr) begin
      case (i_reg_req.addr)
        LINEAR_RAIL_CONFIG_ADDR: begin
          linear_cfg_next = i_reg_req.wdata[LINEAR_USED_BITS-1:0];
        end
        BUCK_A_UNDER_ADDR: a_under_next = under_cfg_t'(i_reg_req.wdata);
        BUCK_A_OVER_ADDR: a_over_next = over_cfg_t'(i_reg_req.wdata);
        BUCK_B_UNDER_ADDR: b_under_next = under_cfg_t'(i_reg_req.wdata);
        BUCK_B_OVER_ADDR: b_over_next = over_cfg_t'(i_reg_req.wdata);
        default: begin
        end
      endcase
    end
  end

  // Register reads answer one cycle after the strobe; unmapped reads give zero.
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = i_reg_req.rd;
    if (i_reg_req.rd) begin
      case (i_reg_req.addr)
        LINEAR_RAIL_CONFIG_ADDR: begin
          rdata_next = {{(8 - LINEAR_USED_BITS){1'b0}}, linear_cfg_reg};
        end
        BUCK_A_UNDER_ADDR: rdata_next = a_under_reg;
        BUCK_A_OVER_ADDR: rdata_next = a_over_reg;
        BUCK_B_UNDER_ADDR: rdata_next = b_under_reg;
        BUCK_B_OVER_ADDR: rdata_next = b_over_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Configuration and read-back registers.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      linear_cfg_reg <= LINEAR_RAIL_CONFIG_RST[LINEAR_USED_BITS-1:0];
      a_under_reg <= under_cfg_t'(UNDER_MONITOR_RST);
      a_over_reg <= over_cfg_t'(OVER_MONITOR_RST);
      b_under_reg <= under_cfg_t'(UNDER_MONITOR_RST);
      b_over_reg <= over_cfg_t'(OVER_MONITOR_RST);
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else if (i_clk_en) begin
      linear_cfg_reg <= linear_cfg_next;
      a_under_reg <= a_under_next;
      a_over_reg <= a_over_next;
      b_under_reg <= b_under_next;
      b_over_reg <= b_over_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;

  // The comparators are analog and asynchronous, so each passes two flops.
  // Bit order: 0 a-under, 1 a-over, 2 b-under, 3 b-over.
  logic [3:0] raw_in;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;

  assign raw_in = {i_buck_b_over_raw, i_buck_b_under_raw, i_buck_a_over_raw,
                   i_buck_a_under_raw};

  // Two-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else if (i_clk_en) begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Filter times per comparator, decoded from each rail's own register.
  logic [FILTER_COUNT_W-1:0] rise_cycles [4];
  logic [FILTER_COUNT_W-1:0] fall_cycles [4];
  logic [3:0] filtered;

  always_comb begin
    rise_cycles[0] = us_to_cycles(long_filter_us(a_under_reg.rise_filter));
    fall_cycles[0] = us_to_cycles(short_filter_us(a_under_reg.fall_filter));
    rise_cycles[1] = us_to_cycles(short_filter_us(a_over_reg.rise_filter));
    fall_cycles[1] = us_to_cycles(long_filter_us(a_over_reg.fall_filter));
    rise_cycles[2] = us_to_cycles(long_filter_us(b_under_reg.rise_filter));
    fall_cycles[2] = us_to_cycles(short_filter_us(b_under_reg.fall_filter));
    rise_cycles[3] = us_to_cycles(short_filter_us(b_over_reg.rise_filter));
    fall_cycles[3] = us_to_cycles(long_filter_us(b_over_reg.fall_filter));
  end

  // One debounce filter per comparator.
  for (genvar g = 0; g < 4; g++) begin : g_filter
    level_debounce u_debounce (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_level(sync2_reg[g]),
      .i_rise_cycles(rise_cycles[g]),
      .i_fall_cycles(fall_cycles[g]),
      .o_level(filtered[g])
    );
  end

  // Output stage registers.
  logic rail_on_reg;
  logic rail_on_next;
  logic discharge_reg;
  logic discharge_next;
  logic [10:0] slope_reg;
  logic [10:0] slope_next;
  rail_limits_t a_limits_reg;
  rail_limits_t a_limits_next;
  rail_limits_t b_limits_reg;
  rail_limits_t b_limits_next;
  rail_fault_t a_fault_reg;
  rail_fault_t a_fault_next;
  rail_fault_t b_fault_reg;
  rail_fault_t b_fault_next;

  // While the sequencer runs it owns the enable and discharge controls; the
  // register bits keep their value and take over again once it stops.
  always_comb begin
    if (i_sequencer_enable) begin
      rail_on_next = i_seq_linear_rail_on;
      discharge_next = i_seq_linear_rail_discharge;
    end else begin
      rail_on_next = linear_cfg_reg[LINEAR_ON_BIT];
      discharge_next = linear_cfg_reg[LINEAR_DISCHARGE_BIT];
    end
    slope_next = SLOPE_BASE_US_PER_V << linear_cfg_reg[LINEAR_SLOPE_LSB +: 2];
    a_limits_next.under_permille = threshold_permille(a_under_reg.threshold);
    a_limits_next.over_permille = threshold_permille(a_over_reg.threshold);
    b_limits_next.under_permille = threshold_permille(b_under_reg.threshold);
    b_limits_next.over_permille = threshold_permille(b_over_reg.threshold);
    a_fault_next.under = filtered[0];
    a_fault_next.over = filtered[1];
    b_fault_next.under = filtered[2];
    b_fault_next.over = filtered[3];
  end

  // Data outputs come from flops, which adds one cycle of latency to each.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rail_on_reg <= 1'b0;
      discharge_reg <= 1'b0;
      slope_reg <= '0;
      a_limits_reg <= '0;
      b_limits_reg <= '0;
      a_fault_reg <= '0;
      b_fault_reg <= '0;
    end else if (i_clk_en) begin
      rail_on_reg <= rail_on_next;
      discharge_reg <= discharge_next;
      slope_reg <= slope_next;
      a_limits_reg <= a_limits_next;
      b_limits_reg <= b_limits_next;
      a_fault_reg <= a_fault_next;
      b_fault_reg <= b_fault_next;
    end
  end

  assign o_linear_rail_on = rail_on_reg;
  assign o_linear_rail_discharge = discharge_reg;
  assign o_linear_rail_ramp_slope = slope_reg;
  assign o_buck_a_limits = a_limits_reg;
  assign o_buck_b_limits = b_limits_reg;
  assign o_buck_a_fault = a_fault_reg;
  assign o_buck_b_fault = b_fault_reg;

endmodule : rail_monitor_config
`default_nettype wire

// file: rail_monitor_config_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rail_monitor_config_checker
  import rail_monitor_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire reg_req_t i_reg_req,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_sequencer_enable,
  input wire logic i_seq_linear_rail_on,
  input wire logic i_seq_linear_rail_discharge,
  input wire logic i_buck_a_under_raw,
  input wire logic i_buck_a_over_raw,
  input wire logic i_buck_b_under_raw,
  input wire logic i_buck_b_over_raw,
  input wire logic o_linear_rail_on,
  input wire logic o_linear_rail_discharge,
  input wire logic [10:0] o_linear_rail_ramp_slope,
  input wire rail_fault_t o_buck_a_fault,
  input wire rail_fault_t o_buck_b_fault
);
  // Release history, so the load after reset is not judged before it can land.
  logic [2:0] up_q;
  always_ff @(posedge i_clk_sys) begin
    up_q <= {up_q[1:0], i_rst_b};
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  // A taken read, and a sequencer value held steady for three enabled edges.
  sequence read_taken;
    i_clk_en && i_reg_req.rd;
  endsequence
  sequence seq_holds(sig);
    (&up_q && i_clk_en && i_sequencer_enable && $stable(i_sequencer_enable) && $stable(sig))[*3];
  endsequence

  a_read_answers: assert property (read_taken |=> o_reg_rvalid)
    else $error("read strobe got no rvalid");
  // A frozen clock enable legally keeps a pending rvalid up, so that case is allowed.
  a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_req.rd && i_clk_en)
    || (!$past(i_clk_en) && $past(o_reg_rvalid)))
    else $error("rvalid without a read");
  a_rdata_holds: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (read_taken ##0
    !(i_reg_req.addr inside {[LINEAR_RAIL_CONFIG_ADDR:BUCK_B_OVER_ADDR]})
    |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_config_upper_zero: assert property (read_taken ##0
    (i_reg_req.addr == LINEAR_RAIL_CONFIG_ADDR) |=> o_reg_rdata[7:4] == 4'h0)
    else $error("unused config bits read nonzero");
  a_seq_owns_on: assert property (seq_holds(i_seq_linear_rail_on)
    |-> o_linear_rail_on == i_seq_linear_rail_on)
    else $error("rail on ignores sequencer");
  a_seq_owns_discharge: assert property (seq_holds(i_seq_linear_rail_discharge)
    |-> o_linear_rail_discharge == i_seq_linear_rail_discharge)
    else $error("discharge ignores sequencer");
  a_slope_table: assert property (&up_q |->
    o_linear_rail_ramp_slope inside {11'h0a0, 11'h140, 11'h280, 11'h500})
    else $error("ramp slope off table");
  // The raw level that decides a filtered edge is captured four edges before that edge is seen here.
  a_a_over_rise: assert property ($rose(o_buck_a_fault.over)
    |-> $past(i_buck_a_over_raw, 4))
    else $error("rail a over fault rose without raw level");
  a_a_under_fall: assert property ($fell(o_buck_a_fault.under)
    |-> !$past(i_buck_a_under_raw, 4))
    else $error("rail a under fault fell with raw level high");
  a_b_over_rise: assert property ($rose(o_buck_b_fault.over)
    |-> $past(i_buck_b_over_raw, 4))
    else $error("rail b over fault rose without raw level");
  a_b_under_fall: assert property ($fell(o_buck_b_fault.under)
    |-> !$past(i_buck_b_under_raw, 4))
    else $error("rail b under fault fell with raw level high");
endmodule : rail_monitor_config_checker

bind rail_monitor_config rail_monitor_config_checker i_chk (
  .i_clk_sys, .i_rst_b, .i_clk_en, .i_reg_req, .o_reg_rdata, .o_reg_rvalid,
  .i_sequencer_enable, .i_seq_linear_rail_on, .i_seq_linear_rail_discharge,
  .i_buck_a_under_raw, .i_buck_a_over_raw, .i_buck_b_under_raw, .i_buck_b_over_raw,
  .o_linear_rail_on, .o_linear_rail_discharge, .o_linear_rail_ramp_slope,
  .o_buck_a_fault, .o_buck_b_fault);
`default_nettype wire

// file: rail_monitor_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rail_monitor_config_tb
  import rail_monitor_pkg::*;
;
  localparam int US = 1;
  localparam logic [6:0] PM [8] = '{7'h1e, 7'h23, 7'h28, 7'h2d, 7'h32, 7'h3c, 7'h50, 7'h64};
  localparam logic [7:0] RV [5] = '{8'h0d, 8'h24, 8'h50, 8'h24, 8'h50};
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_clk_en = 1'b1;
  reg_req_t i_reg_req = '0;
  logic i_sequencer_enable = 1'b0;
  logic i_seq_linear_rail_on = 1'b0;
  logic i_seq_linear_rail_discharge = 1'b0;
  logic [3:0] raw = 4'h0;
  logic [7:0] o_reg_rdata;
  logic o_reg_rvalid;
  logic o_linear_rail_on;
  logic o_linear_rail_discharge;
  logic [10:0] o_linear_rail_ramp_slope;
  rail_limits_t o_buck_a_limits;
  rail_limits_t o_buck_b_limits;
  rail_fault_t o_buck_a_fault;
  rail_fault_t o_buck_b_fault;
  wire logic [3:0] flt;
  int errors = 0;
  int compares = 0;

  // Fault order matches raw: a over, a under, b over, b under.
  assign flt = {o_buck_b_fault, o_buck_a_fault};

  // Filters are shortened to one cycle per microsecond to keep the run brief.
  rail_monitor_config #(.US_CYCLES(US)) i_dut (
    .i_clk_sys, .i_rst_b, .i_clk_en, .i_reg_req, .o_reg_rdata, .o_reg_rvalid,
    .i_sequencer_enable, .i_seq_linear_rail_on, .i_seq_linear_rail_discharge,
    .i_buck_a_under_raw(raw[1]), .i_buck_a_over_raw(raw[0]),
    .i_buck_b_under_raw(raw[3]), .i_buck_b_over_raw(raw[2]),
    .o_linear_rail_on, .o_linear_rail_discharge, .o_linear_rail_ramp_slope,
    .o_buck_a_limits, .o_buck_b_limits, .o_buck_a_fault, .o_buck_b_fault);

  // Free-running system clock.
  always #12.5 i_clk_sys = ~i_clk_sys;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // One byte access; the strobe drops at the taking edge so it is never doubled.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    i_reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_clk_sys);
    i_reg_req <= '0;
    #1;
    q = o_reg_rdata;
    if (!w && i_clk_en) check(o_reg_rvalid, 1'b1);
    @(posedge i_clk_sys);
  endtask : acc

  // Filter time in cycles: long fields scale 32 us, short ones are none or a power of two.
  function automatic int ftime(input int k, input logic [7:0] v, input logic rise);
    logic [2:0] c;
    c = k[0] ? (rise ? {1'b0, v[4:3]} : v[2:0]) : (rise ? v[4:2] : {1'b0, v[1:0]});
    if (rise == k[0]) return (32 << c) * US;
    return (c == 3'h0) ? 0 : (1 << c) * US;
  endfunction : ftime

  // Program one monitor, then glitch (unless bypassed) and settle its raw level both ways.
  task automatic filt(input int k, input logic [2:0] c);
    logic [7:0] v;
    logic [7:0] q;
    int t;
    rail_limits_t lim;
    v = {c, (k[0] ? {c[1:0], c} : {c, c[1:0]})};
    acc(1'b1, 8'h25 + 8'(2 * k[1] + (k[0] ? 0 : 1)), v, q);
    acc(1'b0, 8'h25 + 8'(2 * k[1] + (k[0] ? 0 : 1)), 8'h00, q);
    check(q, v);
    lim = k[1] ? o_buck_b_limits : o_buck_a_limits;
    check(k[0] ? lim.under_permille : lim.over_permille, PM[c]);
    for (int e = 0; e < 2; e++) begin
      t = ftime(k, v, e == 0);
      if (t > 1) begin
        raw[k] <= (e == 0);
        repeat (t - 1) @(posedge i_clk_sys);
        raw[k] <= (e != 0);
        repeat (t + 6) @(posedge i_clk_sys);
        #1 check(flt, (e == 0) ? 0 : (1 << k));
        @(posedge i_clk_sys);
      end
      // The filter counts its own register cycle, so a timed level lands one edge
      // before the bypass figure would suggest; a bypass takes four edges.
      raw[k] <= (e == 0);
      repeat (t + 2 + (t == 0)) @(posedge i_clk_sys);
      #1 check(flt, (e == 0) ? 0 : (1 << k));
      @(posedge i_clk_sys);
      #1 check(flt, (e == 0) ? (1 << k) : 0);
      @(posedge i_clk_sys);
    end
  endtask : filt

  // Watchdog sized well beyond the longest filter sweep.
  initial begin
    repeat (80000) @(posedge i_clk_sys);
    errors++;
    summarize();
  end

  // Main sequence: reset values, config sweep, unmapped and frozen access, filters.
  initial begin
    logic [7:0] q;
    logic [7:0] v;
    void'($urandom(99842));
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(posedge i_clk_sys);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 8'h24 + 8'(i), 8'h00, q);
      check(q, RV[i]);
    end
    check({o_linear_rail_on, o_linear_rail_discharge, o_linear_rail_ramp_slope},
          {2'b11, 11'h280});
    check({o_buck_a_limits, o_buck_b_limits, flt}, {7'h23, 7'h28, 7'h23, 7'h28, 4'h0});
    for (int i = 0; i < 32; i++) begin
      v = 8'($urandom) & 8'hf0 | 8'(i[3:0]);
      i_sequencer_enable <= i[4];
      i_seq_linear_rail_on <= 1'($urandom);
      i_seq_linear_rail_discharge <= 1'($urandom);
      acc(1'b1, 8'h24, v, q);
      acc(1'b0, 8'h24, 8'h00, q);
      check(q, {4'h0, v[3:0]});
      check({o_linear_rail_on, o_linear_rail_discharge, o_linear_rail_ramp_slope},
            {i[4] ? {i_seq_linear_rail_on, i_seq_linear_rail_discharge} : {v[0], v[3]},
             11'h0a0 << v[2:1]});
    end
    acc(1'b1, 8'h29, 8'hff, q);
    acc(1'b0, 8'h29, 8'h00, q);
    check(q, 8'h00);
    i_clk_en <= 1'b0;
    acc(1'b1, 8'h25, 8'h00, q);
    i_clk_en <= 1'b1;
    acc(1'b0, 8'h25, 8'h00, q);
    check(q, 8'h24);
    for (int k = 0; k < 4; k++) begin
      for (int c = 0; c < 8; c++) begin
        filt(k, 3'(c));
      end
    end
    summarize();
  end
endmodule : rail_monitor_config_tb
`default_nettype wire

// file: rail_monitor_pkg.sv
package rail_monitor_pkg;

  // Register offsets on the serial control port.
  localparam logic [7:0] LINEAR_RAIL_CONFIG_ADDR = 8'h24;
  localparam logic [7:0] BUCK_A_UNDER_ADDR = 8'h25;
  localparam logic [7:0] BUCK_A_OVER_ADDR = 8'h26;
  localparam logic [7:0] BUCK_B_UNDER_ADDR = 8'h27;
  localparam logic [7:0] BUCK_B_OVER_ADDR = 8'h28;

  // Reset values.
  localparam logic [7:0] LINEAR_RAIL_CONFIG_RST = 8'h0d;
  localparam logic [7:0] UNDER_MONITOR_RST = 8'h24;
  localparam logic [7:0] OVER_MONITOR_RST = 8'h50;

  // Field positions of the linear rail configuration register.
  localparam int LINEAR_ON_BIT = 0;
  localparam int LINEAR_SLOPE_LSB = 1;
  localparam int LINEAR_DISCHARGE_BIT = 3;
  localparam int LINEAR_USED_BITS = 4;

  // Field positions of the monitor registers.
  localparam int THRESHOLD_LSB = 5;
  localparam int UNDER_RISE_LSB = 3;
  localparam int UNDER_FALL_LSB = 0;
  localparam int OVER_RISE_LSB = 2;
  localparam int OVER_FALL_LSB = 0;

  // Timing: filter times are in microseconds, slopes in microseconds per volt.
  localparam int CLK_PERIOD_NS = 25;
  localparam int MICROSECOND_NS = 1000;
  localparam int CYCLES_PER_US = (MICROSECOND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] LONG_FILTER_BASE_US = 9'h020;
  localparam logic [8:0] SHORT_FILTER_UNIT_US = 9'h001;
  localparam logic [10:0] SLOPE_BASE_US_PER_V = 11'h0a0;
  localparam int FILTER_COUNT_W = 14;

  // Monitor register layouts.
  typedef struct packed {
    logic [2:0] threshold;
    logic [1:0] rise_filter;
    logic [2:0] fall_filter;
  } under_cfg_t;

  typedef struct packed {
    logic [2:0] threshold;
    logic [2:0] rise_filter;
    logic [1:0] fall_filter;
  } over_cfg_t;

  // Register access request from the serial control port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Trip points in tenths of a percent of the programmed voltage.
  typedef struct packed {
    logic [6:0] under_permille;
    logic [6:0] over_permille;
  } rail_limits_t;

  // Filtered comparator levels of one rail.
  typedef struct packed {
    logic under;
    logic over;
  } rail_fault_t;

endpackage : rail_monitor_pkg
